// ### shared/adcsm_pkg.sv
// Register codes, field layout and reset values of the status/mode register pair
package adcsm_pkg;
	localparam logic [2:0] RS_STATUS = 3'h0;
	localparam logic [2:0] RS_MODE = 3'h1;
	localparam logic [2:0] RS_DATA = 3'h3;
	localparam logic [7:0] STATUS_RESET = 8'h80;
	localparam logic [23:0] MODE_RESET = 24'h080060;
	localparam int SR_READY = 7;
	localparam int SR_ERROR = 6;
	localparam int SR_MISSING_REFERENCE_FLAG = 5;
	localparam int SR_PARITY = 4;
	localparam int MR_APPEND = 20;
	localparam int MR_FIXED_ZERO = 14;
	localparam int MR_PARITY = 13;
	localparam int CMD_RW = 6;
	localparam int CMD_RS_HI = 5;
	localparam int CMD_RS_LO = 3;
	localparam logic [5:0] LEN_STATUS = 6'h08;
	localparam logic [5:0] LEN_WORD = 6'h18;
	localparam logic [5:0] LEN_WORD_STATUS = 6'h20;
	localparam logic [5:0] LEN_CMD_TAIL = 6'h07;
	typedef enum logic [3:0] {
		ST_WAIT = 4'h1,
		ST_CMD = 4'h2,
		ST_READ = 4'h4,
		ST_WRITE = 4'h8
	} adcsm_state_t;
endpackage

// ### core/adcsm_regs.sv
// Status and mode registers behind the three-wire serial register port
`timescale 1ns/100ps
// What this block does
// - Read-only 8-bit status, resets to 0x80
// - Status shifted out bit 7 first
// - Ready, error, missing_reference_flag, parity, channel bit layout
// - Ready flag cleared when result loads
// - Ready set after data read, before update
// - Ready set on idle, power-down, sync low
// - Ready also shown on data-out pin
// - Error flag tracks clamped result with ready
// - Calibration faults set error flag
// - Missing reference flag, clamps result high
// - Parity flag shows odd ones count
// - Channel bits name stored result's channel
// - 24-bit read-write mode register, select 001
// - Mode word shifted bit 23 first
// - Mode write resets modulator, sets ready
// - Mode field layout, bit 14 fixed zero
// - Mode register resets to 0x080060
module adcsm_regs (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// Serial pins
	input  wire logic        serialClk,
	input  wire logic        serialIn,
	input  wire logic        chipSelect_n,
	output logic             serialOut,
	output logic             serialOutEn,
	input  wire logic        sync_n,
	// Converter side
	input  wire logic        resultLoad,
	input  wire logic [23:0] resultData,
	input  wire logic [3:0]  resultChannel,
	input  wire logic        resultClamped,
	input  wire logic        updateSoon,
	input  wire logic        convIdle,
	input  wire logic        calFault,
	input  wire logic        refDetectEnable,
	input  wire logic        refBelowThreshold,
	// Mode outputs
	output logic [23:0]      modeWord,
	output logic             modulatorReset
);
	adcsm_pkg::adcsm_state_t state;
	adcsm_pkg::adcsm_state_t next_state;
	logic        sclkA, sclkB, sclkC;
	logic        dinA, dinB;
	logic        csA, csB;
	logic        syncA, syncB;
	logic [6:0]  cmdShift;
	logic [5:0]  bitCount;
	logic [5:0]  xferLen;
	logic [31:0] shiftReg;
	logic [2:0]  regSel;
	logic [23:0] dataReg;
	logic [3:0]  chanReg;
	logic        readyFlag;
	logic        errorFlag;

	// Pins pass two flops before any use
	always_ff @(posedge sys_clk) begin
		sclkA <= serialClk;
		sclkB <= sclkA;
		sclkC <= sclkB;
		dinA <= serialIn;
		dinB <= dinA;
		csA <= chipSelect_n;
		csB <= csA;
		syncA <= sync_n;
		syncB <= syncA;
	end

	wire       active = ~csB;
	wire       sclkRise = sclkB & ~sclkC & active;
	wire [7:0] cmdByte = {cmdShift, dinB};
	wire       cmdDone = state == adcsm_pkg::ST_CMD && sclkRise && bitCount == adcsm_pkg::LEN_CMD_TAIL - 6'h01;
	wire       isRead = cmdByte[adcsm_pkg::CMD_RW];
	wire [2:0] cmdSel = cmdByte[adcsm_pkg::CMD_RS_HI:adcsm_pkg::CMD_RS_LO];
	wire       lastBit = sclkRise && bitCount == xferLen - 6'h01;
	wire       readDone = state == adcsm_pkg::ST_READ && lastBit;
	wire       writeDone = state == adcsm_pkg::ST_WRITE && lastBit;
	wire       dataRead = readDone && regSel == adcsm_pkg::RS_DATA;
	wire       modeWrite = writeDone && regSel == adcsm_pkg::RS_MODE;
	wire       appendOn = modeWord[adcsm_pkg::MR_APPEND];
	wire       refMissing = refDetectEnable & refBelowThreshold;
	wire       parityBit = modeWord[adcsm_pkg::MR_PARITY] & ^dataReg;
	wire [7:0] statusByte = {readyFlag, errorFlag, refMissing, parityBit, chanReg};
	wire [23:0] modeIn = {shiftReg[22:0], dinB};

	// Ready set events win over a load in the same cycle
	wire readySet = dataRead | updateSoon | convIdle | ~syncB | modeWrite;
	wire next_ready = readySet ? 1'b1 : (resultLoad ? 1'b0 : readyFlag);

	always_comb begin
		next_state = state;
		case (state)
			adcsm_pkg::ST_WAIT: begin
				if (sclkRise && !dinB)
					next_state = adcsm_pkg::ST_CMD;
			end
			adcsm_pkg::ST_CMD: begin
				if (cmdDone) begin
					if (isRead)
						next_state = adcsm_pkg::ST_READ;
					else if (cmdSel != adcsm_pkg::RS_STATUS)
						next_state = adcsm_pkg::ST_WRITE;
					else
						next_state = adcsm_pkg::ST_WAIT;
				end
			end
			adcsm_pkg::ST_READ: begin
				if (readDone)
					next_state = adcsm_pkg::ST_WAIT;
			end
			adcsm_pkg::ST_WRITE: begin
				if (writeDone)
					next_state = adcsm_pkg::ST_WAIT;
			end
			default: next_state = adcsm_pkg::ST_WAIT;
		endcase
		if (!active)
			next_state = adcsm_pkg::ST_WAIT;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			state <= adcsm_pkg::ST_WAIT;
		else
			state <= next_state;
	end

	// Bit counter and command capture
	always_ff @(posedge sys_clk) begin
		if (!nrst || !active || (state == adcsm_pkg::ST_WAIT) || cmdDone)
			bitCount <= 6'h00;
		else if (sclkRise)
			bitCount <= bitCount + 6'h01;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			cmdShift <= 7'h00;
		else if (state == adcsm_pkg::ST_CMD && sclkRise)
			cmdShift <= cmdByte[6:0];
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			regSel <= 3'h0;
		else if (cmdDone)
			regSel <= cmdSel;
	end

	// Read words sit left-justified, MSB goes out first
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			shiftReg <= 32'h00000000;
			xferLen <= adcsm_pkg::LEN_STATUS;
		end else if (cmdDone && isRead) begin
			case (cmdSel)
				adcsm_pkg::RS_STATUS: begin
					shiftReg <= {statusByte, 24'h000000};
					xferLen <= adcsm_pkg::LEN_STATUS;
				end
				adcsm_pkg::RS_MODE: begin
					shiftReg <= {modeWord, 8'h00};
					xferLen <= adcsm_pkg::LEN_WORD;
				end
				adcsm_pkg::RS_DATA: begin
					shiftReg <= {dataReg, statusByte};
					xferLen <= appendOn ? adcsm_pkg::LEN_WORD_STATUS : adcsm_pkg::LEN_WORD;
				end
				default: begin
					shiftReg <= 32'h00000000;
					xferLen <= adcsm_pkg::LEN_WORD;
				end
			endcase
		end else if (cmdDone) begin
			shiftReg <= 32'h00000000;
			xferLen <= adcsm_pkg::LEN_WORD;
		end else if ((state == adcsm_pkg::ST_READ || state == adcsm_pkg::ST_WRITE) && sclkRise) begin
			shiftReg <= {shiftReg[30:0], dinB};
		end
	end

	// Bit 14 is forced to zero whatever the host sends
	always_ff @(posedge sys_clk) begin
		if (!nrst)
			modeWord <= adcsm_pkg::MODE_RESET;
		else if (modeWrite)
			modeWord <= modeIn & ~(24'h000001 << adcsm_pkg::MR_FIXED_ZERO);
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			modulatorReset <= 1'b0;
		else
			modulatorReset <= modeWrite;
	end

	// Stored result; a missing reference clamps to all ones
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			dataReg <= 24'h000000;
			chanReg <= 4'h0;
		end else if (resultLoad) begin
			dataReg <= refMissing ? 24'hFFFFFF : resultData;
			chanReg <= resultChannel;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			readyFlag <= adcsm_pkg::STATUS_RESET[adcsm_pkg::SR_READY];
		else
			readyFlag <= next_ready;
	end

	// Calibration fault sets; a load rewrites the flag unless a fault comes in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst)
			errorFlag <= adcsm_pkg::STATUS_RESET[adcsm_pkg::SR_ERROR];
		else if (calFault)
			errorFlag <= 1'b1;
		else if (resultLoad)
			errorFlag <= resultClamped | refMissing;
	end

	// Pin shows data during a read, otherwise the ready level
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			serialOut <= 1'b1;
			serialOutEn <= 1'b0;
		end else begin
			serialOut <= (state == adcsm_pkg::ST_READ) ? shiftReg[31] : readyFlag;
			serialOutEn <= active;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence s_modeWriteDone;
		modeWrite ##1 1'b1;
	endsequence

	sequence s_statusReadCmd;
		cmdDone && isRead && cmdSel == adcsm_pkg::RS_STATUS;
	endsequence

	sequence s_cmdStart;
		state == adcsm_pkg::ST_WAIT && sclkRise && !dinB;
	endsequence

	a_load_clears: assert property (resultLoad && !readySet |=> !readyFlag)
		else $error("ready flag not cleared by load");
	a_mode_sets_ready: assert property (s_modeWriteDone |-> readyFlag && modulatorReset)
		else $error("mode write did not set ready and reset modulator");
	a_sync_sets: assert property (!syncB |=> readyFlag)
		else $error("sync low did not set ready");
	a_dataread_sets: assert property (dataRead |=> readyFlag)
		else $error("data read did not set ready");
	a_mode_zero_bit: assert property (!modeWord[adcsm_pkg::MR_FIXED_ZERO])
		else $error("mode bit 14 not zero");
	a_mode_capture: assert property (modeWrite |=> modeWord[23:15] == $past(modeIn[23:15]))
		else $error("mode word not captured");
	a_chan_held: assert property (!resultLoad |=> $stable(chanReg))
		else $error("channel code changed without load");
	a_parity_flag: assert property (resultLoad && !refMissing && !modeWrite && modeWord[adcsm_pkg::MR_PARITY]
		|=> parityBit == ^$past(resultData))
		else $error("parity flag wrong");
	a_status_order: assert property (s_statusReadCmd |=> shiftReg[31:24] == $past(statusByte))
		else $error("status byte not loaded msb first");
	a_pin_ready: assert property (state != adcsm_pkg::ST_READ |=> serialOut == $past(readyFlag))
		else $error("pin does not show ready");
	a_missing_reference_flag_clamp: assert property (resultLoad && refMissing |=> dataReg == 24'hFFFFFF)
		else $error("missing reference did not clamp");
	a_cmd_start: assert property (s_cmdStart |=> state == adcsm_pkg::ST_CMD)
		else $error("zero enable bit did not start a command");
	a_ones_ignored: assert property (state == adcsm_pkg::ST_WAIT && sclkRise && dinB
		|=> state == adcsm_pkg::ST_WAIT)
		else $error("leading one was not ignored");
	a_abort_idle: assert property (!active |=> state == adcsm_pkg::ST_WAIT)
		else $error("deselect did not return to waiting");
	a_read_ends: assert property (readDone |=> state == adcsm_pkg::ST_WAIT)
		else $error("read did not end after its last bit");
	a_pin_enable: assert property (1'b1 |=> serialOutEn == $past(active))
		else $error("pin enable does not follow select");
	a_error_load: assert property (resultLoad && !calFault
		|=> errorFlag == ($past(resultClamped) || $past(refMissing)))
		else $error("error flag not rewritten by load");
	a_cal_error: assert property (calFault |=> errorFlag)
		else $error("calibration fault did not set error");
	a_append_len: assert property (cmdDone && isRead && cmdSel == adcsm_pkg::RS_DATA && appendOn
		|=> xferLen == adcsm_pkg::LEN_WORD_STATUS)
		else $error("appended read not 32 bits long");
	a_mode_read: assert property (cmdDone && isRead && cmdSel == adcsm_pkg::RS_MODE
		|=> shiftReg[31:8] == $past(modeWord))
		else $error("mode word not loaded for read");
	a_mod_pulse: assert property (modulatorReset |-> $past(modeWrite))
		else $error("modulator reset without mode write");
endmodule // adcsm_regs

// ### testbench/adcsm_host.sv
// Host model driving the three-wire serial register port
`timescale 1ns/100ps
module adcsm_host (
	// Clock
	input  wire logic sys_clk,
	// Serial pins
	output logic      serialClk,
	output logic      serialIn,
	output logic      chipSelect_n,
	input  wire logic serialOut
);
	// Clock parks high and data idles high between frames
	initial begin
		serialClk = 1'b1;
		serialIn = 1'b1;
		chipSelect_n = 1'b1;
	end
	// Half period of 8 cycles covers the pin synchronisers
	task automatic bitx(input logic b, output logic s);
		repeat (8) @(posedge sys_clk);
		#1;
		serialClk = 1'b0;
		serialIn = b;
		repeat (8) @(posedge sys_clk);
		#1;
		s = serialOut;
		serialClk = 1'b1;
	endtask
	task automatic xfer(input logic [7:0] cmd, input int n, input logic [31:0] wr, output logic [31:0] rd);
		logic s;
		chipSelect_n = 1'b0;
		rd = '0;
		for (int i = 7; i >= 0; i--) bitx(cmd[i], s);
		for (int i = n - 1; i >= 0; i--) begin
			bitx(wr[i], s);
			rd = {rd[30:0], s};
		end
		serialIn = 1'b1;
		repeat (16) @(posedge sys_clk);
		#1;
		chipSelect_n = 1'b1;
		// Deselect must be seen before the next frame
		repeat (8) @(posedge sys_clk);
		#1;
	endtask
endmodule // adcsm_host

// ### testbench/testbench.sv
// Self-checking bench for the status/mode register pair
`timescale 1ns/100ps
module testbench;
	logic        sys_clk, nrst, serialClk, serialIn, chipSelect_n, serialOut, serialOutEn, sync_n;
	logic        resultLoad, resultClamped, updateSoon, convIdle, calFault, modulatorReset;
	logic        refDetectEnable, refBelowThreshold;
	logic [23:0] resultData, modeWord;
	logic [3:0]  resultChannel;
	logic [31:0] rd;
	int          miscompares = 0, cmp_count = 0, cycles = 0, pulses = 0;
	adcsm_regs dut_u (.sys_clk, .nrst, .serialClk, .serialIn, .chipSelect_n, .serialOut, .serialOutEn, .sync_n,
		.resultLoad, .resultData, .resultChannel, .resultClamped, .updateSoon, .convIdle, .calFault,
		.refDetectEnable, .refBelowThreshold, .modeWord, .modulatorReset);
	adcsm_host host_u (.sys_clk, .serialClk, .serialIn, .chipSelect_n, .serialOut);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// About 7000 cycles expected; ceiling well above
	always @(posedge sys_clk) begin
		cycles++;
		if (modulatorReset === 1'b1) pulses++;
		if (cycles == 40000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask
	task automatic rd_reg(input logic [2:0] sel, input int n, output logic [31:0] v);
		host_u.xfer({2'b01, sel, 3'b000}, n, 32'hFFFFFFFF, v);
	endtask
	task automatic load(input logic [23:0] d, input logic [3:0] ch, input logic cl);
		step();
		resultData = d;
		resultChannel = ch;
		resultClamped = cl;
		resultLoad = 1'b1;
		step();
		resultLoad = 1'b0;
		repeat (2) step();
	endtask
	initial begin
		{nrst, resultLoad, resultClamped, updateSoon, convIdle, calFault} = '0;
		{refDetectEnable, refBelowThreshold, resultData, resultChannel} = '0;
		sync_n = 1'b1;
		repeat (3) step();
		nrst = 1'b1;
		chk("mode port", {8'h00, adcsm_pkg::MODE_RESET}, {8'h00, modeWord});
		chk("ready pin", 32'h1, {31'h0, serialOut});
		chk("pin enable idle", 32'h0, {31'h0, serialOutEn});
		rd_reg(3'h0, 8, rd);
		chk("status reset", 32'h80, rd);
		rd_reg(3'h1, 24, rd);
		chk("mode reset", 32'h080060, rd);
		host_u.xfer(8'hFF, 0, 32'h0, rd);
		host_u.xfer(8'h00, 0, 32'h0, rd);
		rd_reg(3'h0, 8, rd);
		chk("status kept", 32'h80, rd);
		rd_reg(3'h2, 24, rd);
		chk("unmapped", 32'h0, rd);
		// Update, idle and sync-low ready sets, then a calibration fault
		for (int k = 0; k < 4; k++) begin
			load(24'h000001, 4'h3, 1'b0);
			updateSoon = (k == 0);
			convIdle = (k == 1);
			sync_n = (k != 2);
			calFault = (k == 3);
			repeat (6) step();
			{updateSoon, convIdle, calFault} = '0;
			sync_n = 1'b1;
			rd_reg(3'h0, 8, rd);
			chk("status event", {24'h0, k != 3, k == 3, 6'h03}, rd);
		end
		load(24'h000007, 4'h5, 1'b1);
		chk("ready pin low", 32'h0, {31'h0, serialOut});
		rd_reg(3'h0, 8, rd);
		chk("status after load", 32'h45, rd);
		host_u.xfer(8'h08, 24, 32'h2064FF, rd);
		chk("mode port", 32'h2024FF, {8'h00, modeWord});
		chk("reset pulses", 32'h1, pulses);
		rd_reg(3'h1, 24, rd);
		chk("mode readback", 32'h2024FF, rd);
		rd_reg(3'h0, 8, rd);
		chk("status after mode write", 32'hD5, rd);
		refDetectEnable = 1'b1;
		refBelowThreshold = 1'b1;
		load(24'hFFFFFF, 4'h2, 1'b0);
		rd_reg(3'h0, 8, rd);
		chk("status missing_reference_flag", 32'h62, rd);
		rd_reg(3'h3, 24, rd);
		chk("data", 32'hFFFFFF, rd);
		rd_reg(3'h0, 8, rd);
		chk("ready after data read", 32'hE2, rd);
		// Parity checking goes with status append
		refBelowThreshold = 1'b0;
		host_u.xfer(8'h08, 24, 32'h102000, rd);
		load(24'h000007, 4'h9, 1'b0);
		rd_reg(3'h3, 32, rd);
		chk("data with status", 32'h00000719, rd);
		report_and_stop();
	end
endmodule // testbench
